/* shared/tcu_pkg.sv */
package tcu_pkg;
   localparam int WORD_W = 38;
   localparam int TAG_W = 6;
   localparam int TAG_LO = 32;
   localparam int CHK_W = 5;
   localparam int SEL_W = 4;
   localparam int OP_W = 6;
   localparam int IMM12_W = 12;
   localparam int HALF_W = 32;
   localparam int VEC_W = 64;
   localparam int NUM_CHECKS = 16;
   // Check selector that tests both operands in immediate formats of non-memory ops
   localparam logic [SEL_W-1:0] CHK_HW_ARITH = 4'hD;
   localparam logic [SEL_W-1:0] CHK_FIXNUM = 4'h1;
   // Opcode space split: loads below store base, stores below limit
   localparam logic [OP_W-1:0] OP_STORE_BASE = 6'h10;
   localparam logic [OP_W-1:0] OP_MEM_LIMIT = 6'h20;
   localparam logic [OP_W-1:0] OP_LOAD_COPROC = 6'h03;
   localparam logic [OP_W-1:0] OP_STORE_COPROC = 6'h1F;
   localparam logic [OP_W-1:0] OP_STORE_TAG_ONLY = 6'h15;
   localparam logic [OP_W-1:0] OP_WRITE_COPROC = 6'h2F;
   localparam logic [OP_W-1:0] OP_READ_COPROC = 6'h3F;
   localparam logic [OP_W-1:0] OP_MC_READ = 6'h37;
   localparam logic [OP_W-1:0] OP_MOVE = 6'h23;
   localparam logic [OP_W-1:0] OP_MOVE_TAG = 6'h36;
   localparam logic [OP_W-1:0] OP_RETURN = 6'h32;
   localparam logic [OP_W-1:0] OP_RETURN_SUBVERT = 6'h33;
   localparam logic [OP_W-1:0] OP_BR_NEXT = 6'h3D;
   localparam logic [OP_W-1:0] OP_BR_TAKE = 6'h35;
   localparam logic [OP_W-1:0] OP_COND_TRAP = 6'h39;
   localparam logic [OP_W-1:0] OP_BR_NEXT_TYPE = 6'h3C;
   localparam logic [OP_W-1:0] OP_BR_TAKE_TYPE = 6'h34;
   localparam logic [OP_W-1:0] OP_TYPE_TRAP = 6'h38;
   // Condition nibble to check selector; bit 4 set means no check
   localparam logic [NUM_CHECKS-1:0][CHK_W-1:0] COND_CHECK = {
      5'h10, 5'h07, 5'h0A, 5'h01, 5'h01, 5'h01, 5'h10, 5'h10,
      5'h10, 5'h10, 5'h0D, 5'h0D, 5'h0D, 5'h0D, 5'h0D, 5'h0D};
   localparam int COND_NOCHK_BIT = 4;
   typedef enum logic [1:0] {
      register_register_format = 2'b00,
      short_immediate_format = 2'b01,
      long_immediate_format = 2'b10
   } tcu_fmt_t;
   typedef enum logic [2:0] {
      act_normal = 3'b000, act_error = 3'b001, act_evac = 3'b010, act_indirect = 3'b011,
      act_monitor = 3'b100, act_bound = 3'b101, act_logic = 3'b110
   } tcu_mem_act_t;
   typedef enum logic [3:0] {
      trap_none = 4'b0000, trap_tag_check = 4'b0001, trap_type_test = 4'b0010,
      trap_mem_error = 4'b0011, oldspace_evacuation_trap = 4'b0100, indirection_trap = 4'b0101,
      monitor_forward_trap = 4'b0110, bound_location_trap = 4'b0111, logic_variable_trap = 4'b1000
   } tcu_trap_t;
endpackage : tcu_pkg

/* rtl/tcu_tag_unit.sv */
`timescale 1ns/100ps
`default_nettype none
module tcu_tag_unit
   import tcu_pkg::*;
#(
   parameter logic [NUM_CHECKS-1:0][VEC_W-1:0] CHECK_ALLOW = '1,
   parameter logic [TAG_W-1:0] FIXNUM_TAG = 6'h08
) (
   input wire logic i_ref_clk,
   input wire logic i_rst_n,
   input wire logic i_valid,
   input wire logic [OP_W-1:0] i_opcode,
   input wire tcu_fmt_t i_format,
   input wire logic [CHK_W-1:0] i_check_field,
   input wire logic [CHK_W-1:0] i_cond,
   input wire logic i_half_sel,
   input wire logic i_sense_sel,
   input wire logic [WORD_W-1:0] i_src1,
   input wire logic [WORD_W-1:0] i_src2,
   input wire logic [WORD_W-1:0] i_imm_long,
   input wire logic [IMM12_W-1:0] i_imm_short,
   input wire logic [WORD_W-1:0] i_read_word,
   input wire tcu_mem_act_t i_mem_act,
   input wire logic i_mem_oldspace,
   input wire logic i_page_evac_en,
   output logic o_valid,
   output logic o_trap,
   output tcu_trap_t o_trap_kind,
   output logic [CHK_W-1:0] o_trap_check,
   output logic [OP_W-1:0] o_trap_opcode,
   output logic [TAG_W-1:0] o_trap_src1_tag,
   output logic [TAG_W-1:0] o_trap_src2_tag,
   output logic o_type_hit,
   output logic o_mem_req,
   output logic o_mem_tag_only,
   output logic [WORD_W-1:0] o_mem_wdata,
   output logic o_dest_whole,
   output logic [TAG_W-1:0] o_dest_tag,
   output logic [WORD_W-1:0] o_dest_word
);
   logic [TAG_W-1:0] tag1;
   logic [TAG_W-1:0] tag2;
   logic is_load;
   logic is_store;
   logic is_mem;
   logic is_type_op;
   logic is_cond_op;
   logic no_check;
   logic [SEL_W-1:0] chk_sel;
   logic chk_top;
   logic ok1;
   logic ok2;
   logic check_fail;
   logic [VEC_W-1:0] onehot;
   logic [HALF_W-1:0] half;
   logic [HALF_W-1:0] mask;
   logic type_nonzero;
   logic type_hit_nxt;
   logic evac_cond;
   tcu_trap_t mem_kind;
   tcu_trap_t kind_nxt;
   logic [TAG_W-1:0] dest_tag_nxt;
   logic dest_whole_nxt;
   logic [TAG_W-1:0] src2_low;

   // Operand tags live in the top six bits of each word
   assign tag1 = i_src1[WORD_W-1:TAG_LO];
   assign tag2 = i_src2[WORD_W-1:TAG_LO];

   // Low six bits of source2, named so the move check can look back at them
   assign src2_low = i_src2[TAG_W-1:0];

   // Opcode classes
   assign is_load = (i_opcode < OP_STORE_BASE) && (i_opcode != OP_LOAD_COPROC);
   assign is_store = (i_opcode >= OP_STORE_BASE) && (i_opcode < OP_MEM_LIMIT) && (i_opcode != OP_STORE_COPROC);
   assign is_mem = is_load || is_store;
   assign is_type_op = (i_opcode == OP_BR_NEXT_TYPE) || (i_opcode == OP_BR_TAKE_TYPE) ||
                       (i_opcode == OP_TYPE_TRAP);
   assign is_cond_op = (i_opcode == OP_BR_NEXT) || (i_opcode == OP_BR_TAKE) || (i_opcode == OP_COND_TRAP);

   // Select the check; conditionals take it from the condition field
   always_comb begin
      chk_sel = i_check_field[SEL_W-1:0];
      chk_top = i_check_field[CHK_W-1];
      no_check = is_type_op || (i_opcode == OP_LOAD_COPROC) || (i_opcode == OP_STORE_COPROC) ||
                 (i_opcode == OP_READ_COPROC) || (i_opcode == OP_WRITE_COPROC);
      if (is_cond_op) begin
         chk_sel = COND_CHECK[i_cond[SEL_W-1:0]][SEL_W-1:0];
         chk_top = i_cond[CHK_W-1];
         no_check = COND_CHECK[i_cond[SEL_W-1:0]][COND_NOCHK_BIT];
      end
   end

   // Allowed-tag lookup; a tag outside the set traps
   assign ok1 = CHECK_ALLOW[chk_sel][tag1];
   assign ok2 = CHECK_ALLOW[chk_sel][tag2];

   // Which operands are checked depends on format and opcode class
   always_comb begin
      check_fail = 1'b0;
      if (no_check) begin
         check_fail = 1'b0;
      end else if (is_mem) begin
         check_fail = !ok1;
         if (is_load && (i_format == register_register_format) && (tag2 != FIXNUM_TAG)) begin
            check_fail = 1'b1;
         end
      end else if (i_format == register_register_format) begin
         check_fail = (tag1 != tag2) || !ok1;
      end else if (chk_sel == CHK_HW_ARITH) begin
         check_fail = !ok1 || !ok2;
      end else begin
         check_fail = !ok1;
      end
   end

   // Mask tag test: decode, pick a half, mask, then test sense
   assign onehot = {{(VEC_W-1){1'b0}}, 1'b1} << tag1;
   assign half = i_half_sel ? onehot[VEC_W-1:HALF_W] : onehot[HALF_W-1:0];
   assign mask = (i_format == long_immediate_format) ? i_imm_long[HALF_W-1:0] : i_src2[HALF_W-1:0];
   assign type_nonzero = |(half & mask);
   assign type_hit_nxt = i_sense_sel ? type_nonzero : !type_nonzero;

   // Evacuation needs both an oldspace address and an enabled page
   assign evac_cond = i_mem_oldspace && i_page_evac_en;

   // Referenced-word classification; evacuation outranks pointer traps
   always_comb begin
      mem_kind = trap_none;
      unique case (i_mem_act)
         act_normal: mem_kind = trap_none;
         act_error: mem_kind = trap_mem_error;
         act_evac: mem_kind = evac_cond ? oldspace_evacuation_trap : trap_none;
         act_indirect: mem_kind = evac_cond ? oldspace_evacuation_trap : indirection_trap;
         act_monitor: mem_kind = evac_cond ? oldspace_evacuation_trap : monitor_forward_trap;
         act_bound: mem_kind = evac_cond ? oldspace_evacuation_trap : bound_location_trap;
         act_logic: mem_kind = evac_cond ? oldspace_evacuation_trap : logic_variable_trap;
         default: mem_kind = trap_mem_error; // Undefined action code is treated as an error
      endcase
   end

   // Trap priority: operand check, then mask test, then memory word
   always_comb begin
      kind_nxt = trap_none;
      if (check_fail) begin
         kind_nxt = trap_tag_check;
      end else if ((i_opcode == OP_TYPE_TRAP) && type_hit_nxt) begin
         kind_nxt = trap_type_test;
      end else if (is_mem) begin
         kind_nxt = mem_kind;
      end
   end

   // Destination tag source
   always_comb begin
      dest_tag_nxt = tag1;
      dest_whole_nxt = is_load || (i_opcode == OP_MC_READ) || (i_opcode == OP_READ_COPROC) ||
                       (i_opcode == OP_LOAD_COPROC);
      if (dest_whole_nxt) begin
         dest_tag_nxt = i_read_word[WORD_W-1:TAG_LO];
      end else if ((i_opcode == OP_RETURN) || (i_opcode == OP_RETURN_SUBVERT)) begin
         dest_tag_nxt = (i_format == long_immediate_format) ? i_imm_long[WORD_W-1:TAG_LO] : tag1;
      end else if (i_opcode == OP_MOVE) begin
         dest_tag_nxt = (i_format == register_register_format) ? tag1 : src2_low;
      end else if ((i_opcode == OP_MOVE_TAG) && (i_format == short_immediate_format)) begin
         dest_tag_nxt = i_imm_short[TAG_W-1:0];
      end
   end

   // Valid stage; the flags below are qualified by i_valid, the write data and destination tag and word are not
   always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_valid <= 1'b0;
      end else begin
         o_valid <= i_valid;
      end
   end

   // Trap outputs; the vector fields are loaded only with a trap and hold otherwise
   always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_trap <= 1'b0;
         o_trap_kind <= trap_none;
         o_trap_check <= '0;
         o_trap_opcode <= '0;
         o_trap_src1_tag <= '0;
         o_trap_src2_tag <= '0;
      end else begin
         o_trap <= i_valid && (kind_nxt != trap_none);
         o_trap_kind <= i_valid ? kind_nxt : trap_none;
         if (i_valid && (kind_nxt != trap_none)) begin
            o_trap_check <= {chk_top, chk_sel};
            o_trap_opcode <= i_opcode;
            o_trap_src1_tag <= tag1;
            o_trap_src2_tag <= tag2;
         end
      end
   end

   // Mask test outcome for the branch and trap forms
   always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_type_hit <= 1'b0;
      end else begin
         o_type_hit <= i_valid && is_type_op && type_hit_nxt;
      end
   end

   // Memory request; no other class may reference memory
   always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_mem_req <= 1'b0;
         o_mem_tag_only <= 1'b0;
         o_mem_wdata <= '0;
      end else begin
         o_mem_req <= i_valid && is_mem && (kind_nxt == trap_none);
         o_mem_tag_only <= i_valid && (i_opcode == OP_STORE_TAG_ONLY);
         // Tag-only store carries source1 tag over source2 data
         if (i_opcode == OP_STORE_TAG_ONLY) begin
            o_mem_wdata <= {tag1, i_src2[TAG_LO-1:0]};
         end else begin
            o_mem_wdata <= i_src2;
         end
      end
   end

   // Destination tag and, for reads, the whole word
   always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_dest_whole <= 1'b0;
         o_dest_tag <= '0;
         o_dest_word <= '0;
      end else begin
         o_dest_whole <= i_valid && dest_whole_nxt;
         o_dest_tag <= dest_tag_nxt;
         o_dest_word <= i_read_word;
      end
   end

   // Checks
   property p_rr_mismatch;
      @(posedge i_ref_clk) disable iff (!i_rst_n)
      (i_valid && !no_check && !is_mem && (i_format == register_register_format) && (tag1 != tag2))
      |=> (o_trap && (o_trap_kind == trap_tag_check));
   endproperty
   a_rr_mismatch: assert property (p_rr_mismatch) else $error("tag mismatch did not trap");

   property p_nocheck;
      @(posedge i_ref_clk) disable iff (!i_rst_n)
      (i_valid && is_type_op) |=> (o_trap_kind != trap_tag_check);
   endproperty
   a_nocheck: assert property (p_nocheck) else $error("mask test raised operand check trap");

   property p_load_fixnum;
      @(posedge i_ref_clk) disable iff (!i_rst_n)
      (i_valid && is_load && (i_format == register_register_format) && (tag2 != FIXNUM_TAG))
      |=> o_trap && !o_mem_req;
   endproperty
   a_load_fixnum: assert property (p_load_fixnum) else $error("register load without fixnum index");

   property p_mem_only;
      @(posedge i_ref_clk) disable iff (!i_rst_n)
      o_mem_req |-> $past(is_mem) && $past(i_valid);
   endproperty
   a_mem_only: assert property (p_mem_only) else $error("memory request from non memory op");

   property p_evac_prio;
      @(posedge i_ref_clk) disable iff (!i_rst_n)
      (i_valid && is_mem && !check_fail && evac_cond && (i_mem_act >= act_evac) && (i_mem_act <= act_logic))
      |=> (o_trap_kind == oldspace_evacuation_trap);
   endproperty
   a_evac_prio: assert property (p_evac_prio) else $error("evacuation did not take priority");

   property p_evac_need;
      @(posedge i_ref_clk) disable iff (!i_rst_n)
      (o_trap_kind == oldspace_evacuation_trap) |-> $past(i_mem_oldspace) && $past(i_page_evac_en);
   endproperty
   a_evac_need: assert property (p_evac_need) else $error("evacuation without its condition");

   property p_type_trap;
      @(posedge i_ref_clk) disable iff (!i_rst_n)
      (i_valid && (i_opcode == OP_TYPE_TRAP) && (i_sense_sel == !(|(half & mask))))
      |=> (o_trap_kind != trap_type_test) && !o_type_hit;
   endproperty
   a_type_trap: assert property (p_type_trap) else $error("mask test trapped on wrong sense");

   property p_top_bit;
      @(posedge i_ref_clk) disable iff (!i_rst_n)
      (i_valid && !is_cond_op && check_fail) |=> (o_trap_check == $past(i_check_field));
   endproperty
   a_top_bit: assert property (p_top_bit) else $error("check field lost from trap vector");

   property p_move_tag;
      @(posedge i_ref_clk) disable iff (!i_rst_n)
      ((i_opcode == OP_MOVE) && (i_format != register_register_format))
      |=> (o_dest_tag == $past(src2_low));
   endproperty
   a_move_tag: assert property (p_move_tag) else $error("move tag not from source2 low bits");

   property p_load_whole;
      @(posedge i_ref_clk) disable iff (!i_rst_n)
      (i_valid && is_load) |=> o_dest_whole && (o_dest_tag == o_dest_word[WORD_W-1:TAG_LO]);
   endproperty
   a_load_whole: assert property (p_load_whole) else $error("load did not keep whole word");

   property p_store_full;
      @(posedge i_ref_clk) disable iff (!i_rst_n)
      (is_store && (i_opcode != OP_STORE_TAG_ONLY)) |=> (o_mem_wdata == $past(i_src2));
   endproperty
   a_store_full: assert property (p_store_full) else $error("store did not write whole source2");

   property p_hw_both;
      @(posedge i_ref_clk) disable iff (!i_rst_n)
      (i_valid && !no_check && !is_mem && (i_format != register_register_format) &&
       (chk_sel == CHK_HW_ARITH) && !ok2)
      |=> (o_trap && (o_trap_kind == trap_tag_check));
   endproperty
   a_hw_both: assert property (p_hw_both) else $error("numeric check skipped second source");

   c_evac: cover property (@(posedge i_ref_clk) disable iff (!i_rst_n) o_trap_kind == oldspace_evacuation_trap);
   c_type: cover property (@(posedge i_ref_clk) disable iff (!i_rst_n) o_trap_kind == trap_type_test);
   c_bound: cover property (@(posedge i_ref_clk) disable iff (!i_rst_n) o_trap_kind == bound_location_trap);
   c_req: cover property (@(posedge i_ref_clk) disable iff (!i_rst_n) o_mem_req && o_mem_tag_only);
endmodule : tcu_tag_unit
`default_nettype wire

/* tb/tcu_mem_model.sv */
`timescale 1ns/100ps
`default_nettype none
module tcu_mem_model
   import tcu_pkg::*;
(
   input wire logic i_ref_clk,
   input wire logic i_rst_n,
   input wire logic [4:0] i_addr,
   output logic [WORD_W-1:0] o_read_word,
   output tcu_mem_act_t o_mem_act,
   output logic o_oldspace,
   output logic o_page_evac_en
);
   logic [4:0] flip_r;
   // Low bits churn every cycle, so a stale captured word shows as a mismatch
   always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         flip_r <= 5'h00;
      end else begin
         flip_r <= flip_r + 5'h01;
      end
   end
   // Tag, category and transport qualifiers all decode from the index
   always_comb begin
      o_read_word = {1'b0, i_addr, 27'h5A5A5A5, flip_r};
      o_mem_act = tcu_mem_act_t'(i_addr[2:0]);
      o_oldspace = i_addr[3];
      o_page_evac_en = i_addr[4];
   end
endmodule : tcu_mem_model
`default_nettype wire

/* tb/test_tcu_tag_unit.sv */
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, e, g) begin compares++; if ((g) !== (e)) begin n_mismatch++; \
   $display("Error %s expected %0h seen %0h", nm, e, g); end end
module test_tcu_tag_unit
   import tcu_pkg::*;
;
   localparam logic [TAG_W-1:0] FIX = 6'h08;
   localparam logic [VEC_W-1:0] ONES = '1;
   // Selector 1 admits only the fixnum tag; the numeric selector admits two tags
   localparam logic [NUM_CHECKS-1:0][VEC_W-1:0] ALLOW = {ONES, ONES, 64'h0000_0001_0000_0100,
      {11{ONES}}, 64'h0000_0000_0000_0100, ONES};
   localparam logic [23:0][OP_W-1:0] OPS = {6'h00, 6'h03, 6'h05, 6'h0F, 6'h10, 6'h15, 6'h1F, 6'h1A,
      6'h2F, 6'h3F, 6'h37, 6'h23, 6'h36, 6'h32, 6'h33, 6'h3D, 6'h35, 6'h39, 6'h3C, 6'h34, 6'h38,
      6'h2A, 6'h2C, 6'h12};
   logic i_ref_clk, i_rst_n, i_valid, i_half_sel, i_sense_sel, i_mem_oldspace, i_page_evac_en;
   logic [OP_W-1:0] i_opcode, o_trap_opcode;
   tcu_fmt_t i_format;
   logic [CHK_W-1:0] i_check_field, i_cond, o_trap_check, e_chk;
   logic [WORD_W-1:0] i_src1, i_src2, i_imm_long, i_read_word, o_mem_wdata, o_dest_word;
   logic [IMM12_W-1:0] i_imm_short;
   logic [4:0] addr;
   tcu_mem_act_t i_mem_act;
   logic o_valid, o_trap, o_type_hit, o_mem_req, o_mem_tag_only, o_dest_whole;
   tcu_trap_t o_trap_kind, e_kind;
   logic [TAG_W-1:0] o_trap_src1_tag, o_trap_src2_tag, o_dest_tag, e_tag, e_t1, e_t2;
   logic e_valid, e_hit, e_req, e_whole, e_tonly, armed;
   logic [OP_W-1:0] e_op;
   logic [WORD_W-1:0] e_wdata, e_word;
   int n_mismatch, compares;

   tcu_tag_unit #(.CHECK_ALLOW(ALLOW), .FIXNUM_TAG(FIX)) u_tcu_tag_unit (.i_ref_clk, .i_rst_n,
      .i_valid, .i_opcode, .i_format, .i_check_field, .i_cond, .i_half_sel, .i_sense_sel, .i_src1,
      .i_src2, .i_imm_long, .i_imm_short, .i_read_word, .i_mem_act, .i_mem_oldspace,
      .i_page_evac_en, .o_valid, .o_trap, .o_trap_kind, .o_trap_check, .o_trap_opcode,
      .o_trap_src1_tag, .o_trap_src2_tag, .o_type_hit, .o_mem_req, .o_mem_tag_only, .o_mem_wdata,
      .o_dest_whole, .o_dest_tag, .o_dest_word);
   tcu_mem_model u_tcu_mem_model (.i_ref_clk, .i_rst_n, .i_addr(addr), .o_read_word(i_read_word),
      .o_mem_act(i_mem_act), .o_oldspace(i_mem_oldspace), .o_page_evac_en(i_page_evac_en));

   // Tags lean on the two admitted ones so both pass and fail paths are hit
   function automatic logic [WORD_W-1:0] rnd_word();
      logic [TAG_W-1:0] t;
      t = ($urandom_range(0, 2) == 0) ? FIX : ($urandom_range(0, 1) ? 6'h20 : TAG_W'($urandom));
      return {t, $urandom};
   endfunction : rnd_word

   // Expected outputs for the instruction now on the inputs
   function automatic void predict();
      logic [TAG_W-1:0] t1, t2;
      logic ld, st, mt, cp, nc, fail, ev, r;
      logic [VEC_W-1:0] v;
      logic [HALF_W-1:0] m;
      t1 = i_src1[WORD_W-1:TAG_LO];
      t2 = i_src2[WORD_W-1:TAG_LO];
      cp = i_opcode inside {OP_LOAD_COPROC, OP_STORE_COPROC, OP_WRITE_COPROC, OP_READ_COPROC};
      mt = i_opcode inside {OP_BR_NEXT_TYPE, OP_BR_TAKE_TYPE, OP_TYPE_TRAP};
      ld = !cp && i_opcode < OP_STORE_BASE;
      st = !cp && !ld && i_opcode < OP_MEM_LIMIT;
      e_chk = i_check_field;
      nc = 1'b0;
      if (i_opcode inside {OP_BR_NEXT, OP_BR_TAKE, OP_COND_TRAP}) begin
         e_chk = {i_cond[4], COND_CHECK[i_cond[3:0]][3:0]};
         nc = COND_CHECK[i_cond[3:0]][COND_NOCHK_BIT];
      end
      if (cp || mt || nc) fail = 1'b0;
      else if (ld || st) fail = !ALLOW[e_chk[3:0]][t1] || (ld && i_format == register_register_format && t2 != FIX);
      else if (i_format == register_register_format) fail = t1 != t2 || !ALLOW[e_chk[3:0]][t1];
      else fail = !ALLOW[e_chk[3:0]][t1] || (e_chk[3:0] == CHK_HW_ARITH && !ALLOW[e_chk[3:0]][t2]);
      v = 64'h1 << t1;
      m = (i_format == long_immediate_format) ? i_imm_long[HALF_W-1:0] : i_src2[HALF_W-1:0];
      r = |(m & (i_half_sel ? v[VEC_W-1:HALF_W] : v[HALF_W-1:0]));
      e_hit = i_valid && mt && (i_sense_sel ? r : !r);
      ev = i_mem_oldspace && i_page_evac_en;
      e_kind = trap_none;
      if (fail) e_kind = trap_tag_check;
      else if (e_hit && i_opcode == OP_TYPE_TRAP) e_kind = trap_type_test;
      else if ((ld || st) && i_mem_act != act_normal)
         e_kind = (i_mem_act == act_error || i_mem_act > act_logic) ? trap_mem_error : ev ?
            oldspace_evacuation_trap : (i_mem_act == act_evac) ? trap_none : tcu_trap_t'({1'b0, i_mem_act} + 4'h2);
      if (!i_valid) e_kind = trap_none;
      e_valid = i_valid;
      e_op = i_opcode;
      e_t1 = t1;
      e_t2 = t2;
      e_req = i_valid && (ld || st) && e_kind == trap_none;
      e_tonly = i_valid && i_opcode == OP_STORE_TAG_ONLY;
      e_wdata = (i_opcode == OP_STORE_TAG_ONLY) ? {t1, i_src2[HALF_W-1:0]} : i_src2;
      e_whole = i_valid && (ld || i_opcode inside {OP_MC_READ, OP_READ_COPROC, OP_LOAD_COPROC});
      e_word = i_read_word;
      e_tag = t1;
      if (e_whole) e_tag = i_read_word[WORD_W-1:TAG_LO];
      else if (i_opcode inside {OP_RETURN, OP_RETURN_SUBVERT})
         e_tag = (i_format == long_immediate_format) ? i_imm_long[WORD_W-1:TAG_LO] : t1;
      else if (i_opcode == OP_MOVE && i_format != register_register_format) e_tag = i_src2[TAG_W-1:0];
      else if (i_opcode == OP_MOVE_TAG && i_format == short_immediate_format) e_tag = i_imm_short[TAG_W-1:0];
   endfunction : predict

   task automatic check();
      `CHK("valid", e_valid, o_valid)
      `CHK("trap_kind", e_kind, o_trap_kind)
      `CHK("trap", e_kind != trap_none, o_trap)
      `CHK("type_hit", e_hit, o_type_hit)
      `CHK("mem_req", e_req, o_mem_req)
      `CHK("tag_only", e_tonly, o_mem_tag_only)
      `CHK("mem_wdata", e_wdata, o_mem_wdata)
      `CHK("dest_whole", e_whole, o_dest_whole)
      `CHK("dest_word", e_word, o_dest_word)
      if (e_valid) `CHK("dest_tag", e_tag, o_dest_tag)
      if (e_kind != trap_none) begin
         `CHK("trap_opcode", e_op, o_trap_opcode)
         `CHK("trap_src1", e_t1, o_trap_src1_tag)
         `CHK("trap_src2", e_t2, o_trap_src2_tag)
      end
      if (e_kind == trap_tag_check) `CHK("trap_check", e_chk, o_trap_check)
   endtask : check

   // Single exit point for the verdict
   task automatic stop_test();
      if (n_mismatch == 0 && compares > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask : stop_test

   initial begin
      i_ref_clk = 1'b0;
      forever #25 i_ref_clk = ~i_ref_clk;
   end

   // Guard against a hung run
   initial begin
      #250000;
      n_mismatch++;
      stop_test();
   end

   // Inputs move on the falling edge; outputs are judged one cycle later
   initial begin
      {i_valid, i_half_sel, i_sense_sel, i_opcode, i_check_field, i_cond, addr} = '0;
      {i_src1, i_src2, i_imm_long, i_imm_short} = '0;
      i_format = register_register_format;
      i_rst_n = 1'b0;
      armed = 1'b0;
      n_mismatch = 0;
      compares = 0;
      void'($urandom(32'h480B));
      repeat (12) @(negedge i_ref_clk);
      `CHK("reset_trap", 1'b0, o_trap)
      i_rst_n = 1'b1;
      for (int k = 0; k < 3000; k++) begin
         @(negedge i_ref_clk);
         if (armed) check();
         // Reset was pulled low one cycle ago; the outputs must read idle
         if (k == 1501) `CHK("midreset_valid", 1'b0, o_valid)
         if (k == 1501) `CHK("midreset_req", 1'b0, o_mem_req)
         i_rst_n = (k != 1500);
         i_valid = $urandom_range(0, 7) != 0;
         i_opcode = OPS[$urandom_range(0, 23)];
         i_format = tcu_fmt_t'($urandom_range(0, 2));
         i_check_field = CHK_W'($urandom);
         i_cond = CHK_W'($urandom);
         {i_half_sel, i_sense_sel} = 2'($urandom);
         i_src1 = rnd_word();
         i_src2 = rnd_word();
         if ($urandom_range(0, 1)) i_src2[WORD_W-1:TAG_LO] = i_src1[WORD_W-1:TAG_LO];
         i_imm_long = rnd_word();
         i_imm_short = IMM12_W'($urandom);
         addr = 5'($urandom);
         // Corner cases: every condition code, mask edge bit, every memory category
         if (k < 32) begin
            i_valid = 1'b1;
            i_opcode = OP_COND_TRAP;
            i_cond = 5'(k);
         end else if (k < 36) begin
            i_valid = 1'b1;
            i_opcode = OP_TYPE_TRAP;
            i_format = register_register_format;
            i_src1[WORD_W-1:TAG_LO] = 6'h3F;
            i_src2[HALF_W-1:0] = 32'h8000_0000;
            {i_sense_sel, i_half_sel} = 2'(k);
         end else if (k < 68) begin
            i_valid = 1'b1;
            i_opcode = 6'h00;
            i_format = short_immediate_format;
            i_check_field = 5'h00;
            addr = 5'(k);
         end
         #1;
         predict();
         armed = i_rst_n;
      end
      // The last instruction is still in flight; judge it too
      @(negedge i_ref_clk);
      check();
      stop_test();
   end
endmodule : test_tcu_tag_unit
`default_nettype wire
